// >>> hw/sadc_top.sv
`timescale 1ns/1ps
module sadc_top #(
   parameter int BIT_CYC = sadc_pkg::SAR_BIT_CYC
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic shift_clk_i,
   input wire logic select_n_i,
   input wire logic chan_addr_i,
   input wire logic comp_above_i,
   output logic result_o,
   output logic result_oe_o,
   output logic conv_done_o,
   output logic sample_o,
   output logic [13:0] mux_sel_o,
   output logic [9:0] dac_trial_o
);

   // Link side: only toggles and the last address bit live on the shift clock.
   // The shift clock stops between frames, so all counting is done on mclk.
   logic link_rise_tgl;
   logic link_addr_bit;
   logic link_fall_tgl;

   sadc_pkg::sadc_ctl_t s;
   sadc_pkg::sadc_ctl_t next_s;
   sadc_pkg::sadc_sar_rsp_t sar_rsp;

   always_ff @(posedge shift_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         link_rise_tgl <= 1'b0;
         link_addr_bit <= 1'b0;
      end else begin
         link_rise_tgl <= ~link_rise_tgl;
         link_addr_bit <= chan_addr_i;
      end
   end

   always_ff @(negedge shift_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         link_fall_tgl <= 1'b0;
      end else begin
         link_fall_tgl <= ~link_fall_tgl;
      end
   end

   function automatic logic [13:0] mux_decode(input logic [3:0] code);
      logic [13:0] sel;
      sel = '0;
      if (code <= sadc_pkg::CODE_REF_HI) begin
         sel[code] = 1'b1;
      end else begin
         sel[sadc_pkg::CODE_REF_LO] = 1'b1;
      end
      return sel;
   endfunction : mux_decode

   // Fresh transfer: counters cleared, pin driven, previous MSB shown at once
   function automatic sadc_pkg::sadc_ctl_t begin_seq(input sadc_pkg::sadc_ctl_t x);
      sadc_pkg::sadc_ctl_t y;
      y = x;
      y.st = sadc_pkg::SADC_XFER;
      y.rcnt = '0;
      y.fcnt = '0;
      y.addr = '0;
      y.sample = 1'b0;
      y.sh = x.result;
      y.oe = 1'b1;
      return y;
   endfunction : begin_seq

   always_comb begin
      logic rise_ev;
      logic fall_ev;
      logic cs_fall;
      logic cs_rise;
      logic cs_low;
      logic [4:0] fnext;
      rise_ev = s.rt_s2 ^ s.rt_d;
      fall_ev = s.ft_s2 ^ s.ft_d;
      cs_fall = s.cs_d & ~s.cs_s2;
      cs_rise = ~s.cs_d & s.cs_s2;
      cs_low = ~s.cs_s2;
      fnext = s.fcnt + 5'h01;
      next_s = s;
      next_s.cs_s1 = select_n_i;
      next_s.cs_s2 = s.cs_s1;
      next_s.cs_d = s.cs_s2;
      next_s.rt_s1 = link_rise_tgl;
      next_s.rt_s2 = s.rt_s1;
      next_s.rt_d = s.rt_s2;
      next_s.ft_s1 = link_fall_tgl;
      next_s.ft_s2 = s.ft_s1;
      next_s.ft_d = s.ft_s2;
      next_s.cmd = '0;

      if (sar_rsp.done) begin
         next_s.result = sar_rsp.result;
         next_s.eoc = 1'b1;
         if (s.st == sadc_pkg::SADC_CONV) begin
            next_s.st = sadc_pkg::SADC_IDLE;
         end
      end

      if (cs_rise) begin
         // Clock and address events are ignored from here on
         next_s.oe = 1'b0;
         next_s.sample = 1'b0;
         if (s.st != sadc_pkg::SADC_CONV) begin
            next_s.st = sadc_pkg::SADC_IDLE;
         end
      end else if (cs_fall) begin
         if (s.st == sadc_pkg::SADC_CONV && !sar_rsp.done) begin
            // Result register is left alone; only the running cycle is dropped
            next_s.cmd.abort = 1'b1;
            next_s.eoc = 1'b1;
         end
         next_s = begin_seq(next_s);
      end else if (cs_low) begin
         case (s.st)
            sadc_pkg::SADC_XFER: begin
               if (rise_ev && s.rcnt != sadc_pkg::EDGE_MAX) begin
                  next_s.rcnt = s.rcnt + 5'h01;
                  if (s.rcnt < sadc_pkg::RISE_ADDR_END) begin
                     next_s.addr = {s.addr[2:0], link_addr_bit};
                  end
               end
               if (fall_ev) begin
                  next_s.fcnt = fnext;
                  if (fnext < sadc_pkg::FALL_HOLD) begin
                     next_s.sh = {s.sh[8:0], 1'b0};
                  end
                  if (fnext == sadc_pkg::FALL_SAMPLE) begin
                     next_s.mux = mux_decode(s.addr);
                     next_s.sample = 1'b1;
                  end
                  if (fnext == sadc_pkg::FALL_HOLD) begin
                     next_s.sample = 1'b0;
                     next_s.sh = '0;
                     next_s.eoc = 1'b0;
                     next_s.cmd.start = 1'b1;
                     next_s.st = sadc_pkg::SADC_CONV;
                  end
               end
            end
            sadc_pkg::SADC_CONV: begin
               if (rise_ev && s.rcnt != sadc_pkg::EDGE_MAX) begin
                  next_s.rcnt = s.rcnt + 5'h01;
               end
               if (fall_ev && s.fcnt != sadc_pkg::EDGE_MAX) begin
                  next_s.fcnt = fnext;
               end
               if (sar_rsp.done) begin
                  if (s.fcnt == sadc_pkg::FALL_HOLD || s.fcnt == sadc_pkg::EDGE_MAX) begin
                     // Transfer already over: fast mode, restart on done rising
                     next_s = begin_seq(next_s);
                  end else begin
                     // Eleventh clock came first: slow mode, wait for the last fall
                     next_s.st = sadc_pkg::SADC_TAIL;
                  end
               end
            end
            sadc_pkg::SADC_TAIL: begin
               if (rise_ev && s.rcnt != sadc_pkg::EDGE_MAX) begin
                  next_s.rcnt = s.rcnt + 5'h01;
               end
               if (fall_ev) begin
                  next_s.fcnt = fnext;
                  if (fnext >= sadc_pkg::EDGE_MAX) begin
                     next_s = begin_seq(next_s);
                  end
               end
            end
            default: begin
               next_s.st = s.st;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s.st <= sadc_pkg::SADC_IDLE;
         s.cs_s1 <= 1'b1;
         s.cs_s2 <= 1'b1;
         s.cs_d <= 1'b1;
         s.rt_s1 <= 1'b0;
         s.rt_s2 <= 1'b0;
         s.rt_d <= 1'b0;
         s.ft_s1 <= 1'b0;
         s.ft_s2 <= 1'b0;
         s.ft_d <= 1'b0;
         s.rcnt <= '0;
         s.fcnt <= '0;
         s.addr <= '0;
         s.sh <= sadc_pkg::RESULT_RST;
         s.result <= sadc_pkg::RESULT_RST;
         s.oe <= 1'b0;
         s.eoc <= sadc_pkg::EOC_RST;
         s.sample <= 1'b0;
         s.mux <= '0;
         s.cmd <= '0;
      end else begin
         s <= next_s;
      end
   end

   sadc_sar #(
      .BIT_CYC(BIT_CYC)
   ) u_sar (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .cmd_i(s.cmd),
      .comp_above_i(comp_above_i),
      .trial_o(dac_trial_o),
      .rsp_o(sar_rsp)
   );

   assign result_o = s.sh[9];
   assign result_oe_o = s.oe;
   assign conv_done_o = s.eoc;
   assign sample_o = s.sample;
   assign mux_sel_o = s.mux;

endmodule : sadc_top

// >>> inc/sadc_pkg.sv
package sadc_pkg;

   localparam int RES_W = 10;
   localparam int ADDR_W = 4;
   localparam int N_MUX = 14;
   localparam int CNT_W = 5;

   // Serial edge counts within one transfer
   localparam logic [4:0] RISE_ADDR_END = 5'h04;
   localparam logic [4:0] FALL_SAMPLE = 5'h04;
   localparam logic [4:0] FALL_HOLD = 5'h0A;
   localparam logic [4:0] EDGE_MAX = 5'h10;

   // Channel codes
   localparam logic [3:0] CODE_LAST_EXT = 4'hA;
   localparam logic [3:0] CODE_REF_MID = 4'hB;
   localparam logic [3:0] CODE_REF_LO = 4'hC;
   localparam logic [3:0] CODE_REF_HI = 4'hD;

   // Values after reset and conversion start
   localparam logic [9:0] RESULT_RST = 10'h000;
   localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
   localparam logic [3:0] SAR_MSB_IDX = 4'h9;
   localparam logic EOC_RST = 1'b1;

   // Master clock cycles spent on each bit decision
   localparam int SAR_BIT_CYC = 4;

   typedef enum logic [1:0] {
      SADC_IDLE = 2'b00,
      SADC_XFER = 2'b01,
      SADC_CONV = 2'b11,
      SADC_TAIL = 2'b10
   } sadc_state_t;

   typedef struct packed {
      logic start;
      logic abort;
   } sadc_sar_cmd_t;

   typedef struct packed {
      logic done;
      logic [9:0] result;
   } sadc_sar_rsp_t;

   typedef struct packed {
      logic busy;
      logic comp_s1;
      logic comp_s2;
      logic [3:0] idx;
      logic [7:0] cnt;
      logic [9:0] code;
      sadc_sar_rsp_t rsp;
   } sadc_sar_state_t;

   typedef struct packed {
      sadc_state_t st;
      logic cs_s1;
      logic cs_s2;
      logic cs_d;
      logic rt_s1;
      logic rt_s2;
      logic rt_d;
      logic ft_s1;
      logic ft_s2;
      logic ft_d;
      logic [4:0] rcnt;
      logic [4:0] fcnt;
      logic [3:0] addr;
      logic [9:0] sh;
      logic [9:0] result;
      logic oe;
      logic eoc;
      logic sample;
      logic [13:0] mux;
      sadc_sar_cmd_t cmd;
   } sadc_ctl_t;

endpackage : sadc_pkg

// >>> hw/sadc_sar.sv
`timescale 1ns/1ps
module sadc_sar #(
   parameter int BIT_CYC = sadc_pkg::SAR_BIT_CYC
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire sadc_pkg::sadc_sar_cmd_t cmd_i,
   input wire logic comp_above_i,
   output logic [9:0] trial_o,
   output sadc_pkg::sadc_sar_rsp_t rsp_o
);

   localparam logic [7:0] LAST_CNT = 8'(BIT_CYC - 1);

   sadc_pkg::sadc_sar_state_t s;
   sadc_pkg::sadc_sar_state_t next_s;

   always_comb begin
      logic [9:0] decided;
      decided = s.code;
      next_s = s;
      next_s.comp_s1 = comp_above_i;
      next_s.comp_s2 = s.comp_s1;
      next_s.rsp.done = 1'b0;
      if (s.comp_s2) begin
         decided[s.idx] = 1'b0;
      end
      if (cmd_i.abort) begin
         next_s.busy = 1'b0;
         next_s.code = '0;
      end else if (cmd_i.start) begin
         next_s.busy = 1'b1;
         next_s.code = sadc_pkg::SAR_FIRST_TRIAL;
         next_s.idx = sadc_pkg::SAR_MSB_IDX;
         next_s.cnt = '0;
      end else if (s.busy) begin
         if (s.cnt == LAST_CNT) begin
            // Comparator is read at the end of the slot so its sync delay has settled
            next_s.cnt = '0;
            next_s.code = decided;
            if (s.idx == 4'h0) begin
               // Inputs beyond the references settle every trial the same way
               next_s.busy = 1'b0;
               next_s.rsp.done = 1'b1;
               next_s.rsp.result = decided;
            end else begin
               next_s.code[s.idx - 4'h1] = 1'b1;
               next_s.idx = s.idx - 4'h1;
            end
         end else begin
            next_s.cnt = s.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign trial_o = s.code;
   assign rsp_o = s.rsp;

endmodule : sadc_sar

// >>> testbench/sadc_top_assertions.sv
`timescale 1ns/1ps
module sadc_chk #(
   parameter int BIT_CYC = 4
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic shift_clk_i,
   input wire logic select_n_i,
   input wire logic chan_addr_i,
   input wire logic comp_above_i,
   input wire logic result_o,
   input wire logic result_oe_o,
   input wire logic conv_done_o,
   input wire logic sample_o,
   input wire logic [13:0] mux_sel_o,
   input wire logic [9:0] dac_trial_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   AST_OE_ON: assert property ($fell(select_n_i) |-> ##[1:5] result_oe_o)
      else $error("result pin not enabled after select fall");
   AST_OE_OFF: assert property ($rose(select_n_i) |-> ##[1:5] !result_oe_o)
      else $error("result pin still driven after select rise");
   AST_TAIL_ZERO: assert property ($fell(conv_done_o) |-> !result_o)
      else $error("result pin not low at conversion start");
   AST_HOLD: assert property ($fell(conv_done_o) |-> !sample_o)
      else $error("sampling still on at conversion start");
   AST_CONV_END: assert property ($fell(conv_done_o) |-> ##[1:100] conv_done_o)
      else $error("conversion did not complete");
   AST_MSB_TRIAL: assert property ($fell(conv_done_o) |-> ##[0:4] dac_trial_o == 10'h200)
      else $error("first trial is not the top bit");
   AST_NO_SAMPLE_CONV: assert property (!conv_done_o |-> !sample_o)
      else $error("sampling during conversion");
   AST_ONEHOT: assert property (sample_o |-> $onehot(mux_sel_o))
      else $error("multiplexer select not one-hot");
   AST_ABORT: assert property ($fell(select_n_i) && !conv_done_o |-> ##[1:6] conv_done_o)
      else $error("select fall did not abort conversion");
   cover property ($rose(conv_done_o));
   cover property ($fell(select_n_i) && !conv_done_o);
   cover property (sample_o && mux_sel_o[13]);
endmodule : sadc_chk
bind sadc_top sadc_chk #(.BIT_CYC(BIT_CYC)) u_chk (.mclk_i, .sys_rst_i, .shift_clk_i,
   .select_n_i, .chan_addr_i, .comp_above_i, .result_o, .result_oe_o, .conv_done_o,
   .sample_o, .mux_sel_o, .dac_trial_o);

// >>> testbench/sadc_host.sv
`timescale 1ns/1ps
module sadc_host (
   input wire logic mclk_i,
   input wire logic result_i,
   output logic select_n_o,
   output logic sclk_o,
   output logic addr_o
);
   int half = 5;
   initial begin
      select_n_o = 1'b1;
      sclk_o = 1'b0;
      addr_o = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
   endtask : tick
   // Count n comes from the caller: 10, 11 to 16, or 10 or 16 with select held
   task automatic xfer(input logic [3:0] code, input int n, input bit hold_low,
         output logic [9:0] rd, output logic tail);
      rd = 10'h000;
      tail = 1'b0;
      if (select_n_o) begin
         tick(4);
         select_n_o <= 1'b0; // Early in conversion only, never near its end
         tick(6);
      end
      for (int i = 1; i <= n; i++) begin
         addr_o <= (i <= 4) ? code[4 - i] : ~addr_o;
         tick(half); // Eleventh rise follows the tenth fall by one half period
         if (i <= 10) rd = {rd[8:0], result_i};
         else tail = tail | result_i;
         sclk_o <= 1'b1;
         tick(half);
         sclk_o <= 1'b0;
      end
      tick(2 * half);
      if (!hold_low) select_n_o <= 1'b1;
      addr_o <= ~addr_o;
      tick(1);
   endtask : xfer
   task automatic deselect;
      select_n_o <= 1'b1;
      tick(1);
   endtask : deselect
endmodule : sadc_host

// >>> testbench/sadc_top_tb_top.sv
`timescale 1ns/1ps
module sadc_top_tb_top;
   logic mclk, rst, sclk, sel_n, addr, comp, res, res_oe, done, samp, pin, tail;
   logic [13:0] mux;
   logic [9:0] trial, prev_exp, rd;
   int n_errors = 0;
   int samples_checked = 0;
   // Analog levels per multiplexer input; out-of-range ones probe saturation
   int vin [14] = '{-40, 1, 77, 300, 511, 512, 700, 1000, 1022, 1023, 2000, 512, 0, 1023};
   sadc_top #(.BIT_CYC(8)) dut (.mclk_i(mclk), .sys_rst_i(rst), .shift_clk_i(sclk),
      .select_n_i(sel_n), .chan_addr_i(addr), .comp_above_i(comp), .result_o(res),
      .result_oe_o(res_oe), .conv_done_o(done), .sample_o(samp), .mux_sel_o(mux),
      .dac_trial_o(trial));
   sadc_host u_host (.mclk_i(mclk), .result_i(pin), .select_n_o(sel_n), .sclk_o(sclk),
      .addr_o(addr));
   // A floating pin reads inverted so a read while disabled shows up
   assign pin = res_oe ? res : ~res;
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      for (int k = 0; k < 14; k++) if (mux[k]) comp <= int'(trial) > vin[k];
   end
   function automatic logic [9:0] expv(input logic [3:0] c);
      int v;
      v = vin[(c > 4'hD) ? 12 : c];
      return (v < 0) ? 10'h000 : (v > 1023) ? 10'h3FF : 10'(v);
   endfunction : expv
   task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wait_done;
      int t = 0;
      while (done !== 1'b1 && t < 400) begin
         @(posedge mclk);
         t++;
      end
      check("conv_done", done, 1'b1);
   endtask : wait_done
   task automatic run(input logic [3:0] c, input int n, input bit hold);
      u_host.xfer(c, n, hold, rd, tail);
      check("result", rd, prev_exp);
      check("mux_sel", mux, 14'h1 << ((c > 4'hD) ? 12 : c));
      if (n > 10) check("tail", tail, 1'b0);
      prev_exp = expv(c);
   endtask : run
   task automatic test_codes;
      for (int c = 0; c < 16; c++) begin
         run(4'(c), 10, 1'b0);
         wait_done();
         check("result_oe", res_oe, 1'b0);
      end
      $display("test_codes done");
   endtask : test_codes
   task automatic test_modes;
      int hv [5] = '{5, 5, 5, 12, 12};
      // Idle-high long transfers use counts inside 11..16, held-low ones 10 or 16
      int nv [5] = '{10, 12, 16, 14, 16};
      bit lv [5] = '{1, 0, 1, 0, 1};
      for (int m = 0; m < 5; m++) begin
         u_host.half = hv[m];
         for (int k = 0; k < 3; k++) begin
            run(4'(m * 3 + k + 5), nv[m], lv[m]);
            wait_done();
         end
         u_host.deselect();
      end
      u_host.half = 5;
      $display("test_modes done");
   endtask : test_modes
   task automatic test_abort;
      logic [9:0] keep;
      keep = prev_exp;
      // Aborted channel must convert to a value unlike the kept one, or the check is blind
      run(4'h9, 10, 1'b0);
      prev_exp = keep;
      run(4'h6, 10, 1'b0);
      wait_done();
      run(4'h1, 10, 1'b0);
      wait_done();
      $display("test_abort done");
   endtask : test_abort
   task automatic give_verdict;
      $display("Checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict
   initial begin
      rst = 1'b1;
      comp = 1'b0;
      prev_exp = 10'h000;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      check("reset oe", res_oe, 1'b0);
      check("reset done", done, 1'b1);
      test_codes();
      test_modes();
      test_abort();
      give_verdict();
   end
   initial begin
      #1000000;
      n_errors++;
      give_verdict();
   end
endmodule : sadc_top_tb_top
